// File: common/rccr_consts.vh
// constants for the regulator control configuration register pair
`ifndef RCCR_CONSTS_VH
`define RCCR_CONSTS_VH
`define RCCR_CMD_CTRL1 8'h3C
`define RCCR_CMD_CTRL2 8'h3D
`define RCCR_CTRL1_RST 16'h0000
`define RCCR_CTRL2_RST 16'h0000
`define RCCR_CTRL1_MASK 16'hFFBF
`define RCCR_CTRL2_MASK 16'hFFD8
`define RCCR_C1_DE_DIS 15
`define RCCR_C1_NOSINK 14
`define RCCR_C1_SKIP_TRIM 13
`define RCCR_C1_SKIP_AZ 12
`define RCCR_C1_FORCE_REV 11
`define RCCR_C1_AUDIO 10
`define RCCR_C1_FSW_HI 9
`define RCCR_C1_FSW_LO 7
`define RCCR_C1_SYSAMP_OFF 5
`define RCCR_C1_BYPASS 4
`define RCCR_C1_FAST_REF 3
`define RCCR_C1_STOP_SW 2
`define RCCR_C1_OV_SLEW_DIS 1
`define RCCR_C1_FORCE_5V04 0
`define RCCR_C2_OV_DIS 15
`define RCCR_C2_UV_DIS 14
`define RCCR_C2_REV_RST_SHORT 13
`define RCCR_C2_FAST_RST 12
`define RCCR_C2_FWD_RST_SHORT 11
`define RCCR_C2_DEB_HI 10
`define RCCR_C2_DEB_LO 9
`define RCCR_C2_HOLD_HI 8
`define RCCR_C2_HOLD_LO 6
`define RCCR_C2_REV_SWAP 4
`define RCCR_C2_FWD_SWAP 3
`define RCCR_CLK_KHZ 10000
`define RCCR_DEB0_US 7
`define RCCR_DEB1_US 100
`define RCCR_DEB2_US 500
`define RCCR_DEB3_US 1000
`define RCCR_HOLD0_US 10000
`define RCCR_HOLD1_US 20000
`define RCCR_HOLD2_US 15000
`define RCCR_HOLD3_US 5000
`define RCCR_HOLD4_US 1000
`define RCCR_HOLD5_US 500
`define RCCR_HOLD6_US 100
`define RCCR_HOLD7_US 0
`define RCCR_RST_LONG_US 1300000
`define RCCR_RST_MID_US 150000
`define RCCR_RST_FAST_US 200
`define RCCR_RST_FASTEST_US 10
`endif

// File: core/rccr_regs.v
// control register pair with throttle alert debounce and hold timer
`timescale 1ns/1ns
`include "rccr_consts.vh"
module rccr_regs #(
    parameter HOLD_SCALE = 1
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // decoded word access from the serial front end
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] cmd_i,
    input wire [15:0] wdata_i,
    output reg [15:0] rdata_o,
    output reg rvalid_o,
    output reg hit_o,
    // status from the power stage
    input wire power_good_i,
    input wire overcurrent_i,
    input wire buck_boost_mode_i,
    input wire forward_mode_i,
    input wire adapter_present_i,
    // controls to the power stage
    output reg de_comp_en_o,
    output reg sink_on_slew_en_o,
    output reg skip_trim_o,
    output reg skip_autozero_o,
    output reg force_reverse_o,
    output reg audio_filter_o,
    output reg [2:0] fsw_code_o,
    output reg sys_amp_off_o,
    output reg bypass_o,
    output reg fast_ref_o,
    output reg stop_switching_o,
    output reg ov_slew_mask_o,
    output reg force_5v04_o,
    output reg ov_en_o,
    output reg uv_en_o,
    output reg [31:0] rev_restart_cyc_o,
    output reg [31:0] fwd_restart_cyc_o,
    output reg rev_fast_swap_o,
    output reg fwd_fast_swap_o,
    output reg throttle_alert_o
);
    function [31:0] us2cyc;
        input [31:0] us;
        begin
            us2cyc = us * (`RCCR_CLK_KHZ / 1000); // whole-MHz clock keeps 1.3 s in 32 bits
        end
    endfunction

    function [31:0] restart_cyc;
        input fast;
        input short_sel;
        begin
            if (fast) begin
                restart_cyc = short_sel ? us2cyc(`RCCR_RST_FASTEST_US) :
                    us2cyc(`RCCR_RST_FAST_US);
            end else begin
                restart_cyc = short_sel ? us2cyc(`RCCR_RST_MID_US) :
                    us2cyc(`RCCR_RST_LONG_US);
            end
        end
    endfunction

    // command code decode shared by write, read and hit paths
    function is_ctrl1;
        input [7:0] cmd;
        begin
            is_ctrl1 = (cmd == `RCCR_CMD_CTRL1);
        end
    endfunction

    function is_ctrl2;
        input [7:0] cmd;
        begin
            is_ctrl2 = (cmd == `RCCR_CMD_CTRL2);
        end
    endfunction

    function [15:0] read_mux;
        input [7:0] cmd;
        input [15:0] c1;
        input [15:0] c2;
        begin
            if (is_ctrl1(cmd)) begin
                read_mux = c1;
            end else if (is_ctrl2(cmd)) begin
                read_mux = c2;
            end else begin
                read_mux = 16'h0000;
            end
        end
    endfunction

    function [31:0] deb_cycles;
        input [1:0] code;
        begin
            case (code)
                2'b00: deb_cycles = us2cyc(`RCCR_DEB0_US);
                2'b01: deb_cycles = us2cyc(`RCCR_DEB1_US);
                2'b10: deb_cycles = us2cyc(`RCCR_DEB2_US);
                default: deb_cycles = us2cyc(`RCCR_DEB3_US);
            endcase
        end
    endfunction

    // hold scale only shortens simulation runs; code 7 stays zero
    function [31:0] hold_cycles;
        input [2:0] code;
        begin
            case (code)
                3'h0: hold_cycles = us2cyc(`RCCR_HOLD0_US) / HOLD_SCALE;
                3'h1: hold_cycles = us2cyc(`RCCR_HOLD1_US) / HOLD_SCALE;
                3'h2: hold_cycles = us2cyc(`RCCR_HOLD2_US) / HOLD_SCALE;
                3'h3: hold_cycles = us2cyc(`RCCR_HOLD3_US) / HOLD_SCALE;
                3'h4: hold_cycles = us2cyc(`RCCR_HOLD4_US) / HOLD_SCALE;
                3'h5: hold_cycles = us2cyc(`RCCR_HOLD5_US) / HOLD_SCALE;
                3'h6: hold_cycles = us2cyc(`RCCR_HOLD6_US) / HOLD_SCALE;
                default: hold_cycles = us2cyc(`RCCR_HOLD7_US);
            endcase
        end
    endfunction

    reg [15:0] ctrl1_q;
    reg [15:0] ctrl2_q;
    reg [15:0] ctrl1_d;
    reg [15:0] ctrl2_d;
    reg oc_meta_q;
    reg oc_q;
    reg pg_meta_q;
    reg pg_q;
    reg bb_meta_q;
    reg bb_q;
    reg fwd_meta_q;
    reg fwd_q;
    reg adp_meta_q;
    reg adp_q;
    reg [1:0] st_q;
    reg [31:0] cnt_q;
    reg [31:0] deb_cyc;
    reg [31:0] hold_cyc;
    reg [31:0] hold_lim_q;
    // access to either control register
    wire cmd_hit = is_ctrl1(cmd_i) | is_ctrl2(cmd_i);

    localparam ST_IDLE = 2'b00;
    localparam ST_DEB = 2'b01;
    localparam ST_HOLD = 2'b10;

    // pin synchronisers
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oc_meta_q <= 1'b0;
            oc_q <= 1'b0;
            pg_meta_q <= 1'b0;
            pg_q <= 1'b0;
            bb_meta_q <= 1'b0;
            bb_q <= 1'b0;
            fwd_meta_q <= 1'b0;
            fwd_q <= 1'b0;
            adp_meta_q <= 1'b0;
            adp_q <= 1'b0;
        end else begin
            oc_meta_q <= overcurrent_i;
            oc_q <= oc_meta_q;
            pg_meta_q <= power_good_i;
            pg_q <= pg_meta_q;
            bb_meta_q <= buck_boost_mode_i;
            bb_q <= bb_meta_q;
            fwd_meta_q <= forward_mode_i;
            fwd_q <= fwd_meta_q;
            adp_meta_q <= adapter_present_i;
            adp_q <= adp_meta_q;
        end
    end

    // word writes; skip bits only change while power good
    always @* begin
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        if (wr_i) begin
            if (is_ctrl1(cmd_i)) begin
                ctrl1_d = wdata_i & `RCCR_CTRL1_MASK;
                if (!pg_q) begin
                    ctrl1_d[`RCCR_C1_SKIP_TRIM] = ctrl1_q[`RCCR_C1_SKIP_TRIM];
                    ctrl1_d[`RCCR_C1_SKIP_AZ] = ctrl1_q[`RCCR_C1_SKIP_AZ];
                end
            end else if (is_ctrl2(cmd_i)) begin
                ctrl2_d = wdata_i & `RCCR_CTRL2_MASK;
            end
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl1_q <= `RCCR_CTRL1_RST;
            ctrl2_q <= `RCCR_CTRL2_RST;
            rdata_o <= 16'h0000;
            rvalid_o <= 1'b0;
            hit_o <= 1'b0;
        end else begin
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            rvalid_o <= rd_i;
            hit_o <= (wr_i | rd_i) & cmd_hit;
            if (rd_i) begin
                rdata_o <= read_mux(cmd_i, ctrl1_q, ctrl2_q);
            end
        end
    end

    // decoded controls
    // registered so every power-stage control leaves a flop
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            de_comp_en_o <= 1'b1;
            sink_on_slew_en_o <= 1'b1;
            skip_trim_o <= 1'b0;
            skip_autozero_o <= 1'b0;
            force_reverse_o <= 1'b0;
            audio_filter_o <= 1'b0;
            fsw_code_o <= 3'h0;
            sys_amp_off_o <= 1'b0;
            bypass_o <= 1'b0;
            fast_ref_o <= 1'b0;
            stop_switching_o <= 1'b0;
            ov_slew_mask_o <= 1'b0;
            force_5v04_o <= 1'b0;
            ov_en_o <= 1'b1;
            uv_en_o <= 1'b1;
            rev_fast_swap_o <= 1'b0;
            fwd_fast_swap_o <= 1'b0;
        end else begin
            de_comp_en_o <= ~ctrl1_q[`RCCR_C1_DE_DIS];
            sink_on_slew_en_o <= ~ctrl1_q[`RCCR_C1_NOSINK];
            skip_trim_o <= ctrl1_q[`RCCR_C1_SKIP_TRIM];
            skip_autozero_o <= ctrl1_q[`RCCR_C1_SKIP_AZ];
            force_reverse_o <= ctrl1_q[`RCCR_C1_FORCE_REV];
            audio_filter_o <= ctrl1_q[`RCCR_C1_AUDIO] & ~bb_q;
            fsw_code_o <= ctrl1_q[`RCCR_C1_FSW_HI:`RCCR_C1_FSW_LO];
            sys_amp_off_o <= ctrl1_q[`RCCR_C1_SYSAMP_OFF] & fwd_q & ~adp_q;
            bypass_o <= ctrl1_q[`RCCR_C1_BYPASS];
            fast_ref_o <= ctrl1_q[`RCCR_C1_FAST_REF];
            stop_switching_o <= ctrl1_q[`RCCR_C1_STOP_SW] & fwd_q;
            ov_slew_mask_o <= ctrl1_q[`RCCR_C1_OV_SLEW_DIS];
            force_5v04_o <= ctrl1_q[`RCCR_C1_FORCE_5V04];
            ov_en_o <= ~ctrl2_q[`RCCR_C2_OV_DIS];
            uv_en_o <= ~ctrl2_q[`RCCR_C2_UV_DIS];
            rev_fast_swap_o <= ctrl2_q[`RCCR_C2_REV_SWAP];
            fwd_fast_swap_o <= ctrl2_q[`RCCR_C2_FWD_SWAP];
        end
    end

    // restart waits in clock cycles for the power stage timers
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rev_restart_cyc_o <= `RCCR_RST_LONG_US * (`RCCR_CLK_KHZ / 1000);
            fwd_restart_cyc_o <= `RCCR_RST_LONG_US * (`RCCR_CLK_KHZ / 1000);
        end else begin
            rev_restart_cyc_o <= restart_cyc(ctrl2_q[`RCCR_C2_FAST_RST],
                ctrl2_q[`RCCR_C2_REV_RST_SHORT]);
            fwd_restart_cyc_o <= restart_cyc(ctrl2_q[`RCCR_C2_FAST_RST],
                ctrl2_q[`RCCR_C2_FWD_RST_SHORT]);
        end
    end

    // alert timing selections
    always @* begin
        deb_cyc = deb_cycles(ctrl2_q[`RCCR_C2_DEB_HI:`RCCR_C2_DEB_LO]);
        hold_cyc = hold_cycles(ctrl2_q[`RCCR_C2_HOLD_HI:`RCCR_C2_HOLD_LO]);
    end

    // throttle alert: debounce then minimum hold
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= ST_IDLE;
            cnt_q <= 32'h0;
            hold_lim_q <= 32'h0;
            throttle_alert_o <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    cnt_q <= 32'h1;
                    if (oc_q) begin
                        st_q <= ST_DEB;
                    end
                end
                ST_DEB: begin
                    if (!oc_q) begin
                        st_q <= ST_IDLE;
                    end else if (cnt_q >= deb_cyc) begin
                        st_q <= ST_HOLD;
                        cnt_q <= 32'h0;
                        hold_lim_q <= hold_cyc;
                        throttle_alert_o <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                ST_HOLD: begin
                    // limit latched at assertion; a rewrite mid-hold cannot shorten it
                    if (cnt_q < hold_lim_q) begin
                        cnt_q <= cnt_q + 32'h1;
                    end else if (!oc_q) begin
                        st_q <= ST_IDLE;
                        throttle_alert_o <= 1'b0;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                    throttle_alert_o <= 1'b0;
                end
            endcase
        end
    end
endmodule // rccr_regs

// File: tb/rccr_host_model.sv
// word-access host model for the control register pair
`timescale 1ns/1ns
module rccr_host_model (
    // clock
    input wire clk_i,
    // word access
    output reg wr_o,
    output reg rd_o,
    output reg [7:0] cmd_o,
    output reg [15:0] wdata_o,
    input wire [15:0] rdata_i,
    input wire rvalid_i,
    input wire hit_i
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        cmd_o = 8'h00;
        wdata_o = 16'hA5A5;
    end
    // whole word per write; data scrambled once released
    task write_word(input [7:0] c, input [15:0] d);
        begin
            @(posedge clk_i);
            wr_o <= 1'b1;
            cmd_o <= c;
            wdata_o <= d;
            @(posedge clk_i);
            wr_o <= 1'b0;
            wdata_o <= ~d;
        end
    endtask
    task read_word(input [7:0] c, output [15:0] d, output v, output h);
        begin
            @(posedge clk_i);
            rd_o <= 1'b1;
            cmd_o <= c;
            @(posedge clk_i);
            rd_o <= 1'b0;
            #1;
            d = rdata_i;
            v = rvalid_i;
            h = hit_i;
        end
    endtask
endmodule // rccr_host_model

// File: tb/rccr_regs_bench.sv
// self-checking bench for the control register pair
`timescale 1ns/1ns
module rccr_regs_bench;
    reg clk_i, rst_n_i, pg, oc, bb, fwd, adapter_side_source, v, h;
    reg [15:0] rv;
    wire wr, rd, rvalid, hit, de, snk, trm, az, frev, aud, sys, byp, fref, stp, ovm, f5;
    wire ov, uv, rsw, fsw_w, alert;
    wire [7:0] cmd;
    wire [15:0] wdata, rdata;
    wire [2:0] fsw;
    wire [31:0] rrc, frc;
    integer err_total, compares, i;
    rccr_regs #(.HOLD_SCALE(100)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr),
        .rd_i(rd), .cmd_i(cmd), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
        .hit_o(hit), .power_good_i(pg), .overcurrent_i(oc), .buck_boost_mode_i(bb),
        .forward_mode_i(fwd), .adapter_present_i(adapter_side_source), .de_comp_en_o(de),
        .sink_on_slew_en_o(snk), .skip_trim_o(trm), .skip_autozero_o(az),
        .force_reverse_o(frev), .audio_filter_o(aud), .fsw_code_o(fsw), .sys_amp_off_o(sys),
        .bypass_o(byp), .fast_ref_o(fref), .stop_switching_o(stp), .ov_slew_mask_o(ovm),
        .force_5v04_o(f5), .ov_en_o(ov), .uv_en_o(uv), .rev_restart_cyc_o(rrc),
        .fwd_restart_cyc_o(frc), .rev_fast_swap_o(rsw), .fwd_fast_swap_o(fsw_w),
        .throttle_alert_o(alert));
    rccr_host_model host (.clk_i(clk_i), .wr_o(wr), .rd_o(rd), .cmd_o(cmd),
        .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid), .hit_i(hit));
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("MISMATCH %0s exp %0h got %0h", nm, e, g);
            end
        end
    endtask
    task rdchk(input [7:0] c, input [15:0] e);
        begin
            host.read_word(c, rv, v, h);
            chk("rdata", {16'h0000, e}, {16'h0000, rv});
            chk("hit", 1, h);
            chk("rvalid", 1, v);
        end
    endtask
    task wrs(input [7:0] c, input [15:0] d);
        begin
            host.write_word(c, d);
            repeat (2) @(posedge clk_i);
            #1;
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk_i);
            #1;
        end
    endtask
    task end_of_test;
        begin
            if (err_total == 0 && compares > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #3000000;
        err_total = err_total + 1;
        end_of_test;
    end
    initial begin
        err_total = 0;
        compares = 0;
        rst_n_i = 1'b0;
        {pg, oc, bb, fwd, adapter_side_source} = 5'b10010;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        cyc(2);
        rdchk(8'h3C, 16'h0000);
        rdchk(8'h3D, 16'h0000);
        chk("ovuvde", 3'b111, {ov, uv, de});
        chk("revwait", 13000000, rrc);
        chk("fwdwait", 13000000, frc);
        wrs(8'h3C, 16'hFFFF);
        rdchk(8'h3C, 16'hFFBF);
        chk("c1a", 6'b001111, {de, snk, trm, az, frev, aud});
        chk("c1b", 7'h7F, {sys, byp, fref, stp, ovm, f5, aud});
        @(posedge clk_i);
        {bb, fwd} <= 2'b10;
        cyc(4);
        chk("modes", 3'b000, {aud, stp, sys});
        @(posedge clk_i);
        {pg, bb, fwd} <= 3'b001;
        cyc(4);
        wrs(8'h3C, 16'h0000);
        rdchk(8'h3C, 16'h3000);
        @(posedge clk_i);
        pg <= 1'b1;
        cyc(4);
        for (i = 0; i < 8; i = i + 1) begin
            wrs(8'h3C, {6'h00, i[2:0], 7'h00});
            chk("fsw", i, fsw);
        end
        wrs(8'h3D, 16'hFFFF);
        rdchk(8'h3D, 16'hFFD8);
        chk("c2", 4'b0011, {ov, uv, rsw, fsw_w});
        chk("revwait", 100, rrc);
        chk("fwdwait", 100, frc);
        wrs(8'h3D, 16'h1000);
        chk("revwait", 2000, rrc);
        chk("fwdwait", 2000, frc);
        wrs(8'h3D, 16'h3000);
        chk("revwait", 100, rrc);
        chk("fwdwait", 2000, frc);
        wrs(8'h3D, 16'h2800);
        chk("revwait", 1500000, rrc);
        chk("fwdwait", 1500000, frc);
        host.read_word(8'h3E, rv, v, h);
        chk("unmapped", 0, {rv, h});
        wrs(8'h3D, 16'h0000);
        @(posedge clk_i);
        oc <= 1'b1;
        cyc(60);
        chk("alert", 0, alert);
        cyc(40);
        chk("alert", 1, alert);
        @(posedge clk_i);
        oc <= 1'b0;
        cyc(500);
        chk("alert", 1, alert);
        cyc(600);
        chk("alert", 0, alert);
        wrs(8'h3D, 16'h03C0);
        @(posedge clk_i);
        oc <= 1'b1;
        cyc(900);
        chk("alert", 0, alert);
        cyc(200);
        chk("alert", 1, alert);
        @(posedge clk_i);
        oc <= 1'b0;
        cyc(10);
        chk("alert", 0, alert);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        cyc(2);
        chk("rstwait", 13000000, rrc);
        chk("fsw", 0, fsw);
        rdchk(8'h3C, 16'h0000);
        rdchk(8'h3D, 16'h0000);
        end_of_test;
    end
endmodule // rccr_regs_bench

// File: tb/rccr_regs_properties.sv
// assertions on the control register pair ports
`timescale 1ns/1ns
module rccr_regs_properties (
    // access
    input wire clk_i,
    input wire rst_n_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] cmd_i,
    input wire [15:0] wdata_i,
    input wire [15:0] rdata_o,
    input wire rvalid_o,
    input wire hit_o,
    // status and controls
    input wire overcurrent_i,
    input wire de_comp_en_o,
    input wire [2:0] fsw_code_o,
    input wire bypass_o,
    input wire ov_en_o,
    input wire uv_en_o,
    input wire throttle_alert_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire c1_w = wr_i && cmd_i == 8'h3C;
    wire c2_w = wr_i && cmd_i == 8'h3D;
    wire map_w = cmd_i == 8'h3C || cmd_i == 8'h3D;
    a_read_answer: assert property (rd_i && map_w |=> rvalid_o && hit_o)
        else $error("read not answered");
    a_unmapped_zero: assert property (rd_i && !map_w |=> !hit_o && rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_decomp_follow: assert property (c1_w |=> ##1 de_comp_en_o == !$past(wdata_i[15], 2))
        else $error("comparator enable wrong");
    a_fsw_follow: assert property (c1_w |=> ##1 fsw_code_o == $past(wdata_i[9:7], 2))
        else $error("frequency code wrong");
    a_bypass_follow: assert property (c1_w |=> ##1 bypass_o == $past(wdata_i[4], 2))
        else $error("bypass wrong");
    a_ov_inverse: assert property (c2_w |=> ##1 ov_en_o == !$past(wdata_i[15], 2))
        else $error("ov enable wrong");
    a_uv_inverse: assert property (c2_w |=> ##1 uv_en_o == !$past(wdata_i[14], 2))
        else $error("uv enable wrong");
    a_alert_cause: assert property ($rose(throttle_alert_o) |-> $past(overcurrent_i, 8))
        else $error("alert without overcurrent");
    cover property (c2_w);
    cover property (rd_i && !map_w);
    cover property ($rose(throttle_alert_o));
endmodule // rccr_regs_properties

bind rccr_regs rccr_regs_properties u_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i), .cmd_i(cmd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .hit_o(hit_o),
    .overcurrent_i(overcurrent_i), .de_comp_en_o(de_comp_en_o), .fsw_code_o(fsw_code_o),
    .bypass_o(bypass_o), .ov_en_o(ov_en_o), .uv_en_o(uv_en_o),
    .throttle_alert_o(throttle_alert_o)
);
